/* asbl_map.svh */
// Opcode, field and reset constants for the add-skip and bit-logic unit.
// Assumes the includer runs on one core clock; holds definitions only.
`ifndef ASBL_MAP_SVH
`define ASBL_MAP_SVH

// ------------------------------------------------------------
// First-byte opcodes
// ------------------------------------------------------------
`define ASBL_ADS_IM_HI 4'hA
`define ASBL_OP_ADS_IMM 8'hC9
`define ASBL_OP_ADS_HL 8'h3F
`define ASBL_OP_PREFIX_RR 8'hDC
`define ASBL_OP_AND_IM 8'hDD
`define ASBL_OP_AND_HL 8'h39
`define ASBL_OP_BAND 8'hF5
`define ASBL_OP_ADC_HL 8'h3E

// ------------------------------------------------------------
// Second-byte fields
// ------------------------------------------------------------
`define ASBL_RR_ADS_HI 4'h9
`define ASBL_RR_AND_HI 4'h1
`define ASBL_AND_IM_HI 4'h1
`define ASBL_MEMB_HI 4'h4
`define ASBL_PTR_TOP 2'h0
`define ASBL_MEMA_FB_TOP 2'h2

// ------------------------------------------------------------
// Bit addresses (12-bit data memory space)
// ------------------------------------------------------------
`define ASBL_ADDR_FB0 8'hFB
`define ASBL_ADDR_FF0 8'hFF
`define ASBL_BANK15 4'hF
`define ASBL_MEMB_TOP 2'h3
`define ASBL_PTR_BANK 4'h0

// ------------------------------------------------------------
// Register selects and reset values
// ------------------------------------------------------------
`define ASBL_SEL_CARRY 3'h4
`define ASBL_RST_BYTE 8'h00
`define ASBL_RST_ADDR 12'h000

`endif

/* asbl_pkg.sv */
// Types shared by the add-skip and bit-logic unit.
// Assumes nothing beyond a SystemVerilog compiler.
package asbl_pkg;

  // Decoded operation
  typedef enum logic [3:0] {
    OP_NONE, OP_ADS_IM, OP_ADS_IMM, OP_ADS_HL, OP_ADS_EA_RR, OP_ADS_RR_EA,
    OP_AND_IM, OP_AND_HL, OP_AND_EA_RR, OP_AND_RR_EA, OP_BAND, OP_ADC_HL
  } asbl_op_e;

  // Sequencer state
  typedef enum logic {ST_IDLE, ST_EXEC} asbl_state_e;

endpackage : asbl_pkg

/* asbl_decoder.sv */
// Opcode decoder: turns one or two instruction bytes into an operation.
// Assumes both bytes are presented together; purely combinational.
`timescale 1ns/1ps
`include "asbl_map.svh"

module asbl_decoder (
  input wire logic [7:0] byte0_i,
  input wire logic [7:0] byte1_i,
  output asbl_pkg::asbl_op_e op_o,
  output logic two_cycle_o,
  output logic [1:0] pair_sel_o
);

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  wire is_rr = (byte0_i == `ASBL_OP_PREFIX_RR) && !byte1_i[0];
  wire to_ea = byte1_i[3];
  wire rr_ads = is_rr && (byte1_i[7:4] == `ASBL_RR_ADS_HI);
  wire rr_and = is_rr && (byte1_i[7:4] == `ASBL_RR_AND_HI);
  wire and_im = (byte0_i == `ASBL_OP_AND_IM) && (byte1_i[7:4] == `ASBL_AND_IM_HI);
  // Any of the three bit-address forms may follow the bit-AND opcode
  wire band_ok = byte1_i[7] || (byte1_i[7:4] == `ASBL_MEMB_HI)
                 || (byte1_i[7:6] == `ASBL_PTR_TOP);
  wire band = (byte0_i == `ASBL_OP_BAND) && band_ok;

  // ------------------------------------------------------------
  // Operation select; unknown codes decode as no operation
  // ------------------------------------------------------------
  assign op_o = (byte0_i[7:4] == `ASBL_ADS_IM_HI) ? asbl_pkg::OP_ADS_IM :
                (byte0_i == `ASBL_OP_ADS_IMM) ? asbl_pkg::OP_ADS_IMM :
                (byte0_i == `ASBL_OP_ADS_HL) ? asbl_pkg::OP_ADS_HL :
                (byte0_i == `ASBL_OP_AND_HL) ? asbl_pkg::OP_AND_HL :
                (byte0_i == `ASBL_OP_ADC_HL) ? asbl_pkg::OP_ADC_HL :
                (rr_ads && to_ea) ? asbl_pkg::OP_ADS_EA_RR :
                rr_ads ? asbl_pkg::OP_ADS_RR_EA :
                (rr_and && to_ea) ? asbl_pkg::OP_AND_EA_RR :
                rr_and ? asbl_pkg::OP_AND_RR_EA :
                and_im ? asbl_pkg::OP_AND_IM :
                band ? asbl_pkg::OP_BAND : asbl_pkg::OP_NONE;

  // Single-byte forms and codes that decode to nothing take one cycle, everything else two
  assign two_cycle_o = !(op_o inside {asbl_pkg::OP_NONE, asbl_pkg::OP_ADS_IM,
                        asbl_pkg::OP_ADS_HL, asbl_pkg::OP_AND_HL, asbl_pkg::OP_ADC_HL});
  assign pair_sel_o = byte1_i[2:1];

endmodule : asbl_decoder

/* asbl_adder.sv */
// Nibble or byte adder with overflow out of the top bit of the width.
// Assumes operands already aligned in the low bits; combinational.
`timescale 1ns/1ps

module asbl_adder (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic cin_i,
  input wire logic wide_i,
  output logic [7:0] sum_o,
  output logic ovf_o
);

  // ------------------------------------------------------------
  // Two nibble stages chained; the narrow form stops after the first
  // ------------------------------------------------------------
  wire [4:0] lo_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
  wire [4:0] hi_sum = {1'b0, a_i[7:4]} + {1'b0, b_i[7:4]} + {4'h0, lo_sum[4]};

  // Narrow form keeps the upper nibble of the destination untouched
  assign sum_o = wide_i ? {hi_sum[3:0], lo_sum[3:0]} : {a_i[7:4], lo_sum[3:0]};
  assign ovf_o = wide_i ? hi_sum[4] : lo_sum[4];

endmodule : asbl_adder

/* asbl_exec.sv */
// Execution unit for add-skip, AND, bit-AND and pointer add-with-carry.
// Assumes the fetch logic hands over whole instructions and reacts to
// the skip pulse; data memory reads combinationally at the given address.
`timescale 1ns/1ps
`include "asbl_map.svh"

module asbl_exec (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic instr_valid_i,
  input wire logic [7:0] instr_byte0_i,
  input wire logic [7:0] instr_byte1_i,
  input wire logic [3:0] mem_rdata_i,
  input wire logic reg_wr_i,
  input wire logic [2:0] reg_wr_sel_i,
  input wire logic [7:0] reg_wr_data_i,
  output logic ready_o,
  output logic done_o,
  output logic skip_o,
  output logic [11:0] mem_addr_o,
  output logic [7:0] ea_o,
  output logic [7:0] hl_o,
  output logic [7:0] wx_o,
  output logic [7:0] yz_o,
  output logic carry_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  asbl_pkg::asbl_state_e state_q, state_d; // Sequencer
  logic [7:0] ea_q, ea_d; // Extended accumulator, A is the low nibble
  logic [7:0] pair_q [1:3]; // Pairs: 1 indirect pointer, 2 WX, 3 YZ
  logic [7:0] pair_d [1:3];
  logic carry_q, carry_d; // Carry flag
  logic [7:0] byte0_q, byte1_q; // Instruction held for second cycle
  logic [11:0] mem_addr_q, mem_addr_d; // Data memory address
  logic [1:0] bit_q; // Bit number of a pending bit-AND
  logic ready_q, done_q, skip_q; // Handshake outputs
  logic adc_prev_q; // Last instruction was pointer add-with-carry
  logic adc_ovf_q; // ... and it overflowed

  // Pair read with index 0 meaning the extended accumulator
  function automatic logic [7:0] read_pair(input logic [1:0] idx, input logic [7:0] ea,
                                           input logic [7:0] p1, input logic [7:0] p2,
                                           input logic [7:0] p3);
    case (idx)
      2'h0: read_pair = ea;
      2'h1: read_pair = p1;
      2'h2: read_pair = p2;
      default: read_pair = p3;
    endcase
  endfunction : read_pair

  // ------------------------------------------------------------
  // Decode of either the new or the held instruction
  // ------------------------------------------------------------
  wire in_exec = (state_q == asbl_pkg::ST_EXEC);
  wire [7:0] b0 = in_exec ? byte0_q : instr_byte0_i;
  wire [7:0] b1 = in_exec ? byte1_q : instr_byte1_i;
  asbl_pkg::asbl_op_e op;
  logic two_cycle;
  logic [1:0] psel;

  asbl_decoder u_dec (
    .byte0_i(b0),
    .byte1_i(b1),
    .op_o(op),
    .two_cycle_o(two_cycle),
    .pair_sel_o(psel)
  );

  // Accept only when idle; a one-cycle form commits on the accept edge
  wire accept = ready_q && instr_valid_i;
  wire commit = (accept && !two_cycle) || in_exec;

  // ------------------------------------------------------------
  // Operand routing
  // ------------------------------------------------------------
  wire [7:0] pair_val = read_pair(psel, ea_q, pair_q[1], pair_q[2], pair_q[3]);
  wire op_ads = op inside {asbl_pkg::OP_ADS_IM, asbl_pkg::OP_ADS_IMM, asbl_pkg::OP_ADS_HL,
                           asbl_pkg::OP_ADS_EA_RR, asbl_pkg::OP_ADS_RR_EA};
  wire op_and = op inside {asbl_pkg::OP_AND_IM, asbl_pkg::OP_AND_HL,
                           asbl_pkg::OP_AND_EA_RR, asbl_pkg::OP_AND_RR_EA};
  wire op_to_pair = (op == asbl_pkg::OP_ADS_RR_EA) || (op == asbl_pkg::OP_AND_RR_EA);
  wire op_from_pair = (op == asbl_pkg::OP_ADS_EA_RR) || (op == asbl_pkg::OP_AND_EA_RR);
  wire op_mem = op inside {asbl_pkg::OP_ADS_HL, asbl_pkg::OP_AND_HL, asbl_pkg::OP_ADC_HL};
  wire op_imm4 = (op == asbl_pkg::OP_ADS_IM) || (op == asbl_pkg::OP_AND_IM);
  // 8-bit forms are the byte immediate and the pair forms
  wire wide = (op == asbl_pkg::OP_ADS_IMM) || op_to_pair || op_from_pair;

  // Destination is the pair for pair-destination forms, else the accumulator
  wire [7:0] opnd_a = op_to_pair ? pair_val : ea_q;
  wire [7:0] opnd_b = op_to_pair ? ea_q :
                      op_from_pair ? pair_val :
                      op_mem ? {4'h0, mem_rdata_i} :
                      (op == asbl_pkg::OP_ADS_IMM) ? b1 :
                      (op == asbl_pkg::OP_AND_IM) ? {4'h0, b1[3:0]} :
                      op_imm4 ? {4'h0, b0[3:0]} : 8'h00; // A,imm4 add-skip nibble

  // Carry feeds only the add-with-carry; add-skip ignores it
  wire use_cin = (op == asbl_pkg::OP_ADC_HL);
  logic [7:0] sum;
  logic sum_ovf;

  asbl_adder u_add (
    .a_i(opnd_a),
    .b_i(opnd_b),
    .cin_i(use_cin && carry_q),
    .wide_i(wide),
    .sum_o(sum),
    .ovf_o(sum_ovf)
  );

  // AND result; narrow forms leave the upper accumulator nibble alone
  wire [7:0] and_res = wide ? (opnd_a & opnd_b) : {opnd_a[7:4], opnd_a[3:0] & opnd_b[3:0]};
  wire [7:0] result = op_and ? and_res : sum;

  // ------------------------------------------------------------
  // Pairing with a preceding pointer add-with-carry
  // ------------------------------------------------------------
  // Only the A,imm4 form is affected, and only after the pointer form
  wire paired = (op == asbl_pkg::OP_ADS_IM) && adc_prev_q;
  wire squash = paired && adc_ovf_q;
  wire writes = (op_ads && !squash) || op_and || (op == asbl_pkg::OP_ADC_HL);
  // Executed paired form never raises its own skip
  wire skip_now = commit && op_ads && !paired && sum_ovf;

  // ------------------------------------------------------------
  // Bit address forming for the bit-AND
  // ------------------------------------------------------------
  wire [11:0] mema_addr = {(b1[6] ? `ASBL_ADDR_FF0 : `ASBL_ADDR_FB0), b1[3:0]};
  wire [11:0] memb_addr = {`ASBL_BANK15, `ASBL_MEMB_TOP, b1[3:0], pair_q[1][3:2]};
  wire [11:0] ptr_addr = {`ASBL_PTR_BANK, pair_q[1][7:4], b1[3:0]};
  wire is_memb = (b1[7:4] == `ASBL_MEMB_HI);
  wire [11:0] bit_addr = b1[7] ? mema_addr : is_memb ? memb_addr : ptr_addr;
  wire [1:0] bit_sel = is_memb ? pair_q[1][1:0] : b1[5:4];
  wire band_acc = accept && (op == asbl_pkg::OP_BAND);

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // Commits win over the side write port; sources are never written
  always_comb begin
    state_d = (accept && two_cycle) ? asbl_pkg::ST_EXEC : asbl_pkg::ST_IDLE;
    ea_d = ea_q;
    pair_d = pair_q;
    carry_d = carry_q;
    if (commit) begin
      if (writes && op_to_pair) begin
        if (psel == 2'h0) begin
          ea_d = result;
        end else begin
          pair_d[psel] = result;
        end
      end else if (writes) begin
        ea_d = result;
      end
      if (op == asbl_pkg::OP_ADC_HL) begin
        carry_d = sum_ovf;
      end else if (op == asbl_pkg::OP_BAND && !mem_rdata_i[bit_q]) begin
        carry_d = 1'b0;
      end
    end else if (reg_wr_i) begin
      if (reg_wr_sel_i == `ASBL_SEL_CARRY) begin
        carry_d = reg_wr_data_i[0];
      end else if (reg_wr_sel_i[1:0] == 2'h0) begin
        ea_d = reg_wr_data_i;
      end else begin
        pair_d[reg_wr_sel_i[1:0]] = reg_wr_data_i;
      end
    end
  end

  // Address follows the pointer pair so pointer reads see data at once;
  // it is held only while a second cycle is still to come, so the pointer
  // is back in place for an instruction taken right after a bit-AND
  assign mem_addr_d = band_acc ? bit_addr :
                      (state_d == asbl_pkg::ST_EXEC) ? mem_addr_q :
                      {`ASBL_PTR_BANK, pair_d[1]};

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Architectural state
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ea_q <= `ASBL_RST_BYTE;
      pair_q <= '{default: `ASBL_RST_BYTE};
      carry_q <= 1'b0;
    end else begin
      ea_q <= ea_d;
      pair_q <= pair_d;
      carry_q <= carry_d;
    end
  end

  // Sequencer and held instruction
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= asbl_pkg::ST_IDLE;
      byte0_q <= `ASBL_RST_BYTE;
      byte1_q <= `ASBL_RST_BYTE;
      bit_q <= 2'h0;
    end else begin
      state_q <= state_d;
      if (accept) begin
        byte0_q <= instr_byte0_i;
        byte1_q <= instr_byte1_i;
        bit_q <= bit_sel;
      end
    end
  end

  // Handshake and pairing flags; pairing flags change only when something commits
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ready_q <= 1'b0;
      done_q <= 1'b0;
      skip_q <= 1'b0;
      mem_addr_q <= `ASBL_RST_ADDR;
      adc_prev_q <= 1'b0;
      adc_ovf_q <= 1'b0;
    end else begin
      ready_q <= (state_d == asbl_pkg::ST_IDLE);
      done_q <= commit;
      skip_q <= skip_now;
      mem_addr_q <= mem_addr_d;
      if (commit) begin
        adc_prev_q <= (op == asbl_pkg::OP_ADC_HL);
        adc_ovf_q <= (op == asbl_pkg::OP_ADC_HL) && sum_ovf;
      end
    end
  end

  assign ready_o = ready_q;
  assign done_o = done_q;
  assign skip_o = skip_q;
  assign mem_addr_o = mem_addr_q;
  assign ea_o = ea_q;
  assign hl_o = pair_q[1];
  assign wx_o = pair_q[2];
  assign yz_o = pair_q[3];
  assign carry_o = carry_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_ADS_CARRY_KEPT: assert property (
    commit && op_ads |=> carry_q == $past(carry_q))
    else $error("add-skip changed the carry flag");

  AST_SKIP_ON_OVF: assert property (
    commit && op_ads && !paired |=> skip_q == $past(sum_ovf) && done_q)
    else $error("skip does not follow overflow");

  AST_ADS_IM_ONE: assert property (
    accept && op == asbl_pkg::OP_ADS_IM |=> done_q && ready_q)
    else $error("A,imm4 add-skip not done in one cycle");

  AST_ADS_IMM_TWO: assert property (
    accept && op == asbl_pkg::OP_ADS_IMM |=> !done_q && !ready_q ##1 done_q && ready_q)
    else $error("byte add-skip not done in two cycles");

  AST_PTR_ADS_ONE: assert property (
    accept && op == asbl_pkg::OP_ADS_HL
    |=> done_q && ea_q[3:0] == $past(ea_q[3:0] + mem_rdata_i))
    else $error("pointer add-skip result wrong");

  AST_SQUASH: assert property (
    commit && squash |=> !skip_q && ea_q == $past(ea_q) && carry_q == $past(carry_q))
    else $error("paired add-skip not squashed");

  AST_PAIRED_NO_SKIP: assert property (
    commit && paired |=> !skip_q)
    else $error("paired add-skip raised a skip");

  AST_AND_PTR: assert property (
    accept && op == asbl_pkg::OP_AND_HL
    |=> done_q && ea_q[3:0] == ($past(ea_q[3:0]) & $past(mem_rdata_i)))
    else $error("pointer AND result wrong");

  AST_BAND_CARRY: assert property (
    commit && op == asbl_pkg::OP_BAND
    |=> carry_q == ($past(carry_q) & $past(mem_rdata_i[bit_q])))
    else $error("bit AND carry wrong");

  AST_BAND_ADDR: assert property (
    band_acc |=> mem_addr_q == $past(bit_addr) && !ready_q ##1 done_q)
    else $error("bit AND address or timing wrong");

  AST_ADC_CARRY: assert property (
    commit && op == asbl_pkg::OP_ADC_HL |=> carry_q == $past(sum_ovf) && !skip_q)
    else $error("add-with-carry carry wrong");

endmodule : asbl_exec

/* testbench.sv */
// Self-checking bench for the add-skip and bit-logic execution unit.
// Assumes asbl_pkg and asbl_exec are compiled first; one core clock.
`timescale 1ns/1ps

module testbench;
  // ------------------------------------------------------------
  // Signals, memory and reference state
  // ------------------------------------------------------------
  typedef struct packed {
    logic sk;
    logic [7:0] ea;
    logic [7:0] hl;
    logic [7:0] wx;
    logic [7:0] yz;
    logic cy;
    logic [63:0] t;
  } asbl_note_s;
  logic clk = 1'b0;
  logic rst, valid, wr_en, ready, done, skip, cy;
  logic [7:0] b0, b1, wdata, ea, hl, wx, yz;
  logic [2:0] wsel;
  logic [11:0] maddr;
  logic [3:0] rdata;
  logic [3:0] mem [0:4095]; // Data memory, read combinationally
  logic [7:0] pr [0:3]; // Reference pairs: 0 EA, 1 HL, 2 WX, 3 YZ
  logic m_cy, prev_adc, adc_ovf; // Reference carry and pairing state
  logic [31:0] rnd_q = 32'h5249B4FF;
  asbl_note_s nq [$]; // Expected results, oldest first
  asbl_note_s cur;
  int n_fail = 0;
  int samples_checked = 0;

  // Clock and memory model
  always #5 clk = ~clk;
  assign rdata = mem[maddr];

  asbl_exec u_asbl_exec (
    .core_clk_i(clk), .sys_rst_i(rst), .instr_valid_i(valid),
    .instr_byte0_i(b0), .instr_byte1_i(b1), .mem_rdata_i(rdata),
    .reg_wr_i(wr_en), .reg_wr_sel_i(wsel), .reg_wr_data_i(wdata),
    .ready_o(ready), .done_o(done), .skip_o(skip), .mem_addr_o(maddr),
    .ea_o(ea), .hl_o(hl), .wx_o(wx), .yz_o(yz), .carry_o(cy)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Xorshift keeps the run repeatable
  function automatic logic [31:0] rnd();
    rnd_q = rnd_q ^ (rnd_q << 13);
    rnd_q = rnd_q ^ (rnd_q >> 17);
    rnd_q = rnd_q ^ (rnd_q << 5);
    return rnd_q;
  endfunction : rnd

  task automatic fail(input string msg);
    n_fail++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : fail

  task automatic chk1(input string w, input logic g, input logic e);
    samples_checked++;
    if (g !== e) fail($sformatf("%s got %b exp %b", w, g, e));
  endtask : chk1

  task automatic chk8(input string w, input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) fail($sformatf("%s got %h exp %h", w, g, e));
  endtask : chk8

  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // Reference model: called at the taking edge, notes the expected commit
  task automatic predict(input logic [7:0] c0, input logic [7:0] c1, input logic [63:0] t0);
    logic [8:0] s;
    logic [3:0] m;
    logic [11:0] ba;
    logic [1:0] bn, r;
    logic sk, adc, two;
    sk = 1'b0;
    adc = 1'b0;
    r = c1[2:1];
    m = mem[{4'h0, pr[1]}];
    // Prefix codes that decode to nothing commit in one cycle
    two = (c0 == 8'hC9 || c0 == 8'hDD || c0 == 8'hF5 ||
           (c0 == 8'hDC && (c1[7:4] == 4'h9 || c1[7:4] == 4'h1)));
    s = {5'h00, pr[0][3:0]} + {5'h00, (c0[7:4] == 4'hA) ? c0[3:0] : m};
    if (c0[7:4] == 4'hA) begin
      if (!(prev_adc && adc_ovf)) begin
        pr[0][3:0] = s[3:0];
        sk = s[4] && !prev_adc;
      end
    end else case (c0)
      8'hC9: begin
        s = {1'b0, pr[0]} + {1'b0, c1};
        pr[0] = s[7:0];
        sk = s[8];
      end
      8'h3F: begin
        pr[0][3:0] = s[3:0];
        sk = s[4];
      end
      8'h3E: begin
        s = s + {8'h00, m_cy};
        pr[0][3:0] = s[3:0];
        m_cy = s[4];
        adc = 1'b1;
      end
      8'h39: pr[0][3:0] = pr[0][3:0] & m;
      8'hDD: pr[0][3:0] = pr[0][3:0] & c1[3:0];
      8'hDC: begin
        s = {1'b0, pr[0]} + {1'b0, pr[r]};
        if (c1[7:4] == 4'h9) begin
          pr[c1[3] ? 2'd0 : r] = s[7:0];
          sk = s[8];
        end
        if (c1[7:4] == 4'h1) pr[c1[3] ? 2'd0 : r] = pr[0] & pr[r];
      end
      8'hF5: begin
        case (c1[7:6])
          2'b10: ba = {8'hFB, c1[3:0]};
          2'b11: ba = {8'hFF, c1[3:0]};
          2'b00: ba = {4'h0, pr[1][7:4], c1[3:0]};
          default: ba = {6'h3F, c1[3:0], pr[1][3:2]};
        endcase
        bn = (c1[7:6] == 2'b01) ? pr[1][1:0] : c1[5:4];
        if (mem[ba][bn] == 1'b0) m_cy = 1'b0;
      end
      default: ;
    endcase
    adc_ovf = s[4];
    prev_adc = adc;
    nq.push_back('{sk, pr[0], pr[1], pr[2], pr[3], m_cy, t0 + 64'd5 + (two ? 64'd10 : 64'd0)});
  endtask : predict

  // Offers one instruction; valid stays up so 1-byte forms go back to back
  task automatic issue(input logic [7:0] c0, input logic [7:0] c1);
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 50) begin
      @(posedge clk);
      #1;
      k++;
    end
    valid = 1'b1;
    b0 = c0;
    b1 = c1;
    @(posedge clk);
    predict(c0, c1, $time);
    #1;
  endtask : issue

  // Waits for all noted commits so side writes never meet a commit edge
  task automatic drain;
    int k;
    k = 0;
    valid = 1'b0;
    while (nq.size() != 0 && k < 50) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (nq.size() != 0) fail("no completion");
  endtask : drain

  // Loads EA, HL, WX, YZ and carry through the side port, strobe held up
  task automatic setup(input logic [39:0] v);
    for (int s = 0; s < 5; s++) begin
      wsel = 3'(s);
      wdata = v[8*s +: 8];
      wr_en = 1'b1;
      @(posedge clk);
      #1;
      if (s == 4) m_cy = v[32];
      else pr[s] = v[8*s +: 8];
    end
    wr_en = 1'b0;
  endtask : setup

  // ------------------------------------------------------------
  // Result watcher
  // ------------------------------------------------------------
  // Done stands one cycle, so it is looked at mid-cycle
  always @(negedge clk) begin
    if (!rst && skip === 1'b1 && done !== 1'b1) fail("skip without done");
    if (!rst && done === 1'b1) begin
      if (nq.size() == 0) fail("unexpected done");
      else begin
        cur = nq.pop_front();
        chk1("skip", skip, cur.sk);
        chk8("ea", ea, cur.ea);
        chk8("hl", hl, cur.hl);
        chk8("wx", wx, cur.wx);
        chk8("yz", yz, cur.yz);
        chk1("carry", cy, cur.cy);
        chk1("latency", ($time == cur.t) ? 1'b1 : 1'b0, 1'b1);
      end
    end
  end

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    logic [31:0] v;
    int sel;
    rst = 1'b1;
    {valid, wr_en, b0, b1, wsel, wdata} = '0;
    {m_cy, prev_adc, adc_ovf} = 3'b000;
    for (int i = 0; i < 4; i++) pr[i] = 8'h00;
    for (int i = 0; i < 4096; i++) mem[i] = 4'(rnd());
    repeat (3) @(posedge clk);
    #1;
    chk1("ready in reset", ready, 1'b0);
    chk8("ea in reset", ea, 8'h00);
    rst = 1'b0;
    @(posedge clk);
    #1;
    chk1("ready after reset", ready, 1'b1);
    // Decimal adjust pairs: 8+9 squashes the add-skip, 3+4 keeps it
    setup(40'h00_0000_2008);
    mem[12'h020] = 4'h9;
    issue(8'hA6, 8'h00);
    issue(8'h3E, 8'h00);
    issue(8'hAA, 8'h00);
    drain();
    setup(40'h00_0000_2003);
    mem[12'h020] = 4'h4;
    issue(8'hA6, 8'h00);
    issue(8'h3E, 8'h00);
    issue(8'hAA, 8'h00);
    drain();
    // Random mix of every form; add-with-carry forms get an add-skip next
    sel = 0;
    for (int it = 0; it < 40; it++) begin
      setup(40'({rnd(), rnd()}) & 40'h01_FFFF_FFFF);
      for (int st = 0; st < 12; st++) begin
        if (sel != 3 && sel != 9) sel = int'(rnd() % 11);
        else sel = 0;
        v = rnd();
        case (sel)
          0: issue({4'hA, v[3:0]}, v[15:8]);
          1: issue(8'hC9, v[7:0]);
          2: issue(8'h3F, v[15:8]);
          3: issue(8'h3E, v[15:8]);
          4: issue(8'h39, v[15:8]);
          5: issue(8'hDD, {4'h1, v[3:0]});
          6: issue(8'hDC, {4'h9, v[3:1], 1'b0});
          7: issue(8'hDC, {4'h1, v[3:1], 1'b0});
          8: issue(8'hF5, (v[7:6] == 2'b01) ? {4'h4, v[3:0]} : v[7:0]);
          9: issue(8'hDC, {4'hA, v[3:1], 1'b0});
          default: issue(8'h00, v[7:0]);
        endcase
      end
      drain();
    end
    repeat (3) @(posedge clk);
    finish_test();
  end

  initial begin
    #100000;
    fail("timeout");
    finish_test();
  end
endmodule : testbench
